// ---- include/dpr_ecc_if.sv ----
// carrier between the block and its sec-ded codec
`timescale 1ns/1ps
interface dpr_ecc_if;
   logic [63:0] enc_data;
   logic [7:0]  enc_check;
   logic [63:0] dec_data;
   logic [7:0]  dec_check;
   logic [63:0] dec_out;
   logic        sbe;
   logic        dbe;
   modport codec (input enc_data, dec_data, dec_check, output enc_check, dec_out, sbe, dbe);
   modport user (output enc_data, dec_data, dec_check, input enc_check, dec_out, sbe, dbe);
endinterface : dpr_ecc_if

// ---- include/dpr_pkg.sv ----
// shared constants of the dual-port ram / fifo block
package dpr_pkg;
   // register byte offsets
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_AFULL  = 8'h04;
   localparam logic [7:0]  ADDR_AEMPTY = 8'h08;
   localparam logic [7:0]  ADDR_FSTAT  = 8'h0c;
   localparam logic [7:0]  ADDR_ISTAT  = 8'h10;
   localparam logic [7:0]  ADDR_IMASK  = 8'h14;
   localparam logic [7:0]  ADDR_FRST   = 8'h18;
   // control register fields
   localparam int          CTRL_FIFO   = 0;
   localparam int          CTRL_SPLIT  = 1;
   localparam int          CTRL_SRW    = 2;
   localparam int          CTRL_ECC    = 3;
   localparam int          CTRL_WA_LSB = 4;
   localparam int          CTRL_WB_LSB = 8;
   localparam int          CTRL_MRATE  = 12;
   localparam int          CTRL_CASC   = 13;
   // reset values
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [15:0] AFULL_RST   = 16'h0100;
   localparam logic [15:0] AEMPTY_RST  = 16'h0004;
   // width codes: 1,2,4,9,18,36,72 bits
   localparam logic [2:0]  W_X36       = 3'h5;
   localparam logic [2:0]  W_X72       = 3'h6;
   localparam logic [2:0]  W_MAX_HALF  = 3'h4;
   // fifo capacities in data-bit units
   localparam logic [15:0] CAP_FULL    = 16'h8000;
   localparam logic [15:0] CAP_HALF    = 16'h4000;
   // cascade keeps this many free write words before it stops asking
   localparam logic [15:0] CASC_MARGIN = 16'h0004;
   // interrupt status bits
   localparam int          IRQ_SBE     = 0;
   localparam int          IRQ_DBE     = 1;
   localparam int          IRQ_OVF     = 2;
   localparam int          IRQ_UNF     = 3;
   localparam int          IRQ_N       = 4;
endpackage : dpr_pkg

// ---- rtl/dpr_ecc_codec.sv ----
// combinational hamming sec-ded encoder and decoder for 64-bit words
`timescale 1ns/1ps
module dpr_ecc_codec (
   dpr_ecc_if.codec e
);
   logic [71:1] cw_e;
   logic [71:1] cw_d;
   logic [6:0]  pe;
   logic [6:0]  sd;
   logic        perr;

   // data sits on the non power-of-two code positions 3..71
   always_comb begin
      int j;
      j = 0;
      cw_e = '0;
      cw_d = '0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw_e[p] = e.enc_data[j];
            cw_d[p] = e.dec_data[j];
            j++;
         end
      end
      pe = '0;
      sd = e.dec_check[6:0];
      for (int k = 0; k < 7; k++) begin
         for (int p = 1; p < 72; p++) begin
            if (p[k]) begin
               pe[k] = pe[k] ^ cw_e[p];
               sd[k] = sd[k] ^ cw_d[p];
            end
         end
      end
      perr = (^e.dec_data) ^ (^e.dec_check);
      // a syndrome beyond the word can only come from several flips
      if (perr && sd != 7'h00 && sd < 7'h48) begin
         cw_d[sd] = ~cw_d[sd];
      end
      j = 0;
      e.dec_out = '0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            e.dec_out[j] = cw_d[p];
            j++;
         end
      end
      e.enc_check = {(^e.enc_data) ^ (^pe), pe};
      e.sbe = perr && sd < 7'h48;
      e.dbe = (!perr && sd != 7'h00) || (perr && sd >= 7'h48);
   end
endmodule : dpr_ecc_codec

// ---- rtl/dpr_ram_fifo.sv ----
// 36kb dual-port memory with split halves, fifo controller, ecc and apb registers
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - ports take widths 1 to 72 bits
// - each port picks its width independently, except that B is forced to 36 in split read/write when both sides are below 36
// - array splits into two independent halves
// - widest width (72, or 36 in a half) only in split read/write mode
// - split read/write: A writes, B reads
// - one side fixed at 36 or 72
// - true dual-port allows variable widths both sides
// - ecc stores eight check bits, corrects, detects
// - ecc codec usable standalone for external memory
// - fifo on full array or one half
// - fifo synchronous or multirate operation
// - fifo generates its own addresses
// - fifo gives full, empty, almost flags
// - almost flags assert at programmed counts
// - fifo widths differ per side
// - cascade path chains fifos deeper
module dpr_ram_fifo (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // port a (fifo write side)
   input  wire logic        a_en,
   input  wire logic        a_we,
   input  wire logic        a_ce,
   input  wire logic [14:0] a_addr,
   input  wire logic [71:0] a_din,
   output logic      [71:0] a_dout,
   // port b (fifo read side)
   input  wire logic        b_en,
   input  wire logic        b_we,
   input  wire logic        b_ce,
   input  wire logic [14:0] b_addr,
   input  wire logic [71:0] b_din,
   output logic      [71:0] b_dout,
   output logic             b_valid,
   output logic             ecc_sbe,
   output logic             ecc_dbe,
   // fifo flags
   output logic             fifo_full,
   output logic             fifo_empty,
   output logic             fifo_afull,
   output logic             fifo_aempty,
   // cascade
   input  wire logic        casc_in_valid,
   input  wire logic [71:0] casc_in_data,
   output logic             casc_in_ready,
   input  wire logic        casc_out_ready,
   // standalone codec
   input  wire logic [63:0] ext_enc_data,
   output logic      [7:0]  ext_enc_check,
   input  wire logic [71:0] ext_dec_data,
   output logic      [63:0] ext_dec_out,
   output logic             ext_sbe,
   output logic             ext_dbe,
   // interrupt
   output logic             irq
);
   logic [71:0]          mem [512];
   logic [31:0]          ctrl_reg;
   logic [15:0]          afull_thr_reg;
   logic [15:0]          aempty_thr_reg;
   logic [dpr_pkg::IRQ_N-1:0] istat_reg;
   logic [dpr_pkg::IRQ_N-1:0] imask_reg;
   logic [15:0]          wptr_reg;
   logic [15:0]          rptr_reg;
   logic [15:0]          wptr_next;
   logic [15:0]          rptr_next;
   logic                 fifo_on, split, srw, ecc_on, mrate, casc;
   logic [2:0]           wa_raw, wb_raw, lim, wa, wb, wb_lim;
   logic [14:0]          ua, ub;
   logic [8:0]           row_a, row_b;
   logic [5:0]           off_a, off_b;
   logic [15:0]          u_w, u_r, cap, occ, occ_next;
   logic                 full_now, empty_now;
   logic                 push_req, push, pop_req, pop;
   logic                 a_wr, a_rd, b_wr, b_rd, a_write, b_read;
   logic                 ecc_wr, ecc_rd;
   logic [71:0]          a_wsrc, a_row, b_row, b_fix;
   logic [143:0]         lay_a, lay_b;
   logic                 wr_acc, setup, mapped;
   logic [31:0]          rd_mux;
   logic [dpr_pkg::IRQ_N-1:0] ev, clr;

   dpr_ecc_if ecc_i ();
   dpr_ecc_if ext_i ();

   // where bit p of a row sits inside element off of width code c
   function automatic void map_pos(input logic [2:0] c, input logic [5:0] off, input int p,
                                   output logic hit, output int idx);
      int j;
      hit = 1'b0;
      idx = 0;
      j = p - 64;
      if (p < 64) begin
         hit = ((p >> c) == int'(off));
         idx = p & ((1 << c) - 1);
      end else if (c >= 3'h3) begin
         hit = ((j >> (c - 3'h3)) == int'(off));
         idx = (1 << c) + (j & ((1 << (c - 3'h3)) - 1));
      end
   endfunction : map_pos

   // returns {mask, placed data}
   function automatic logic [143:0] lay(input logic [2:0] c, input logic [5:0] off, input logic [71:0] din);
      logic h;
      int   ix;
      lay = '0;
      for (int p = 0; p < 72; p++) begin
         map_pos(c, off, p, h, ix);
         lay[72+p] = h;
         lay[p] = din[ix];
      end
   endfunction : lay

   function automatic logic [71:0] pick(input logic [2:0] c, input logic [5:0] off, input logic [71:0] row);
      logic h;
      int   ix;
      pick = '0;
      for (int p = 0; p < 72; p++) begin
         map_pos(c, off, p, h, ix);
         if (h) begin
            pick[ix] = row[p];
         end
      end
   endfunction : pick

   assign fifo_on = ctrl_reg[dpr_pkg::CTRL_FIFO];
   assign split   = ctrl_reg[dpr_pkg::CTRL_SPLIT];
   assign srw     = ctrl_reg[dpr_pkg::CTRL_SRW];
   assign ecc_on  = ctrl_reg[dpr_pkg::CTRL_ECC];
   assign mrate   = ctrl_reg[dpr_pkg::CTRL_MRATE];
   assign casc    = ctrl_reg[dpr_pkg::CTRL_CASC];
   assign wa_raw  = ctrl_reg[dpr_pkg::CTRL_WA_LSB +: 3];
   assign wb_raw  = ctrl_reg[dpr_pkg::CTRL_WB_LSB +: 3];

   // width selection
   always_comb begin
      if (split) begin
         lim = srw ? dpr_pkg::W_X36 : dpr_pkg::W_MAX_HALF;
      end else begin
         lim = srw ? dpr_pkg::W_X72 : dpr_pkg::W_X36;
      end
      wa = (wa_raw > lim) ? lim : wa_raw;
      wb_lim = (wb_raw > lim) ? lim : wb_raw;
      // keep one side at a fixed wide width
      if (srw && wa < dpr_pkg::W_X36 && wb_lim < dpr_pkg::W_X36) begin
         wb = dpr_pkg::W_X36;
      end else begin
         wb = wb_lim;
      end
   end

   // fifo addresses come from the pointers
   assign ua = fifo_on ? wptr_reg[14:0] : (a_addr << wa);
   assign ub = fifo_on ? rptr_reg[14:0] : (b_addr << wb);
   // halves: a owns the lower half, b and the fifo the upper
   assign row_a = split ? {fifo_on, ua[13:6]} : ua[14:6];
   assign row_b = split ? {1'b1, ub[13:6]} : ub[14:6];
   // element offset within a 72-bit row
   assign off_a = ua[5:0] >> wa;
   assign off_b = ub[5:0] >> wb;

   // fifo occupancy in data-bit units, so mixed widths share one count
   // each side advances by its own width
   assign u_w = 16'h0001 << wa;
   assign u_r = 16'h0001 << wb;
   assign cap = split ? dpr_pkg::CAP_HALF : dpr_pkg::CAP_FULL;
   assign occ = wptr_reg - rptr_reg;
   assign full_now = (cap - occ) < u_w;
   assign empty_now = occ < u_r;

   // multirate sides advance only on their own enables
   // cascade input replaces port a as the fifo source
   assign push_req = fifo_on && (casc ? casc_in_valid : (a_en && a_we)) && (!mrate || a_ce);
   // pushes into a full fifo are dropped
   assign push = push_req && !full_now;
   // cascade drains automatically while the next stage has room
   assign pop_req = fifo_on && (!mrate || b_ce) && (casc ? (casc_out_ready && !empty_now) : b_en);
   // pops from an empty fifo are dropped
   assign pop = pop_req && !empty_now;

   // split read/write mode: a only writes, b only reads
   assign a_wr = !fifo_on && a_en && a_we;
   assign a_rd = !fifo_on && a_en && !a_we && !srw;
   assign b_wr = !fifo_on && b_en && b_we && !srw;
   assign b_rd = !fifo_on && b_en && (srw || !b_we);
   assign a_write = a_wr || push;
   assign b_read = b_rd || pop;

   // ecc applies to full 64-bit words
   assign ecc_wr = ecc_on && wa == dpr_pkg::W_X72;
   assign ecc_rd = ecc_on && wb == dpr_pkg::W_X72;

   assign a_row = mem[row_a];
   assign b_row = mem[row_b];

   assign ecc_i.enc_data = a_wsrc[63:0];
   assign ecc_i.dec_data = b_row[63:0];
   assign ecc_i.dec_check = b_row[71:64];
   assign ext_i.enc_data = ext_enc_data;
   assign ext_i.dec_data = ext_dec_data[63:0];
   assign ext_i.dec_check = ext_dec_data[71:64];

   dpr_ecc_codec u_ecc (
      .e (ecc_i.codec)
   );

   // a second codec serves logic outside the array
   dpr_ecc_codec u_ext_ecc (
      .e (ext_i.codec)
   );

   always_comb begin
      a_wsrc = (fifo_on && casc) ? casc_in_data : a_din;
      // store eight check bits in the parity lanes
      if (ecc_wr) begin
         a_wsrc = {ecc_i.enc_check, a_din[63:0]};
         if (fifo_on && casc) begin
            a_wsrc = {ecc_i.enc_check, casc_in_data[63:0]};
         end
      end
      lay_a = lay(wa, off_a, a_wsrc);
      lay_b = lay(wb, off_b, b_din);
      // correct single flips on the way out
      b_fix = ecc_rd ? {b_row[71:64], ecc_i.dec_out} : b_row;
   end

   // array has no reset: contents are undefined until written
   always_ff @(posedge pclk) begin
      if (a_write) begin
         mem[row_a] <= (a_row & ~lay_a[143:72]) | (lay_a[71:0] & lay_a[143:72]);
      end
      // b after a: a same-row collision in true dual-port keeps b's bits
      if (b_wr) begin
         mem[row_b] <= (b_row & ~lay_b[143:72]) | (lay_b[71:0] & lay_b[143:72]);
      end
   end

   // read ports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_dout  <= '0;
         b_dout  <= '0;
         b_valid <= 1'b0;
         ecc_sbe <= 1'b0;
         ecc_dbe <= 1'b0;
      end else begin
         if (a_rd) begin
            a_dout <= pick(wa, off_a, a_row);
         end
         if (b_read) begin
            b_dout <= pick(wb, off_b, b_fix);
         end
         b_valid <= b_read;
         ecc_sbe <= b_read && ecc_rd && ecc_i.sbe;
         ecc_dbe <= b_read && ecc_rd && ecc_i.dbe;
      end
   end

   // fifo pointers and flags
   assign wptr_next = wptr_reg + (push ? u_w : 16'h0000);
   assign rptr_next = rptr_reg + (pop ? u_r : 16'h0000);
   assign occ_next = wptr_next - rptr_next;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_reg      <= '0;
         rptr_reg      <= '0;
         fifo_full     <= 1'b0;
         fifo_empty    <= 1'b1;
         fifo_afull    <= 1'b0;
         fifo_aempty   <= 1'b1;
         casc_in_ready <= 1'b0;
      end else begin
         if (wr_acc && paddr == dpr_pkg::ADDR_FRST && pwdata[0]) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
         end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
         end
         // four flags from the updated occupancy
         fifo_full  <= (cap - occ_next) < u_w;
         fifo_empty <= occ_next < u_r;
         // almost flags compare whole words against thresholds
         fifo_afull  <= (occ_next >> wa) >= afull_thr_reg;
         fifo_aempty <= (occ_next >> wb) <= aempty_thr_reg;
         // margin covers words already in flight from the upstream stage
         casc_in_ready <= fifo_on && casc && (((cap - occ_next) >> wa) >= dpr_pkg::CASC_MARGIN);
      end
   end

   // standalone codec outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_enc_check <= '0;
         ext_dec_out   <= '0;
         ext_sbe       <= 1'b0;
         ext_dbe       <= 1'b0;
      end else begin
         ext_enc_check <= ext_i.enc_check;
         ext_dec_out   <= ext_i.dec_out;
         ext_sbe       <= ext_i.sbe;
         ext_dbe       <= ext_i.dbe;
      end
   end

   // apb: zero-wait access, answer prepared in the setup cycle
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && pready;
   assign mapped = paddr == dpr_pkg::ADDR_CTRL || paddr == dpr_pkg::ADDR_AFULL
                || paddr == dpr_pkg::ADDR_AEMPTY || paddr == dpr_pkg::ADDR_FSTAT
                || paddr == dpr_pkg::ADDR_ISTAT || paddr == dpr_pkg::ADDR_IMASK
                || paddr == dpr_pkg::ADDR_FRST;

   always_comb begin
      unique case (paddr)
         dpr_pkg::ADDR_CTRL:   rd_mux = ctrl_reg;
         dpr_pkg::ADDR_AFULL:  rd_mux = {16'h0000, afull_thr_reg};
         dpr_pkg::ADDR_AEMPTY: rd_mux = {16'h0000, aempty_thr_reg};
         dpr_pkg::ADDR_FSTAT:  rd_mux = {occ, 12'h000, fifo_aempty, fifo_afull, fifo_empty, fifo_full};
         dpr_pkg::ADDR_ISTAT:  rd_mux = {28'h0000000, istat_reg};
         dpr_pkg::ADDR_IMASK:  rd_mux = {28'h0000000, imask_reg};
         default:              rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg       <= dpr_pkg::CTRL_RST;
         afull_thr_reg  <= dpr_pkg::AFULL_RST;
         aempty_thr_reg <= dpr_pkg::AEMPTY_RST;
         imask_reg      <= '0;
      end else if (wr_acc) begin
         if (paddr == dpr_pkg::ADDR_CTRL) begin
            ctrl_reg <= {18'h00000, pwdata[13:0]};
         end
         if (paddr == dpr_pkg::ADDR_AFULL) begin
            afull_thr_reg <= pwdata[15:0];
         end
         if (paddr == dpr_pkg::ADDR_AEMPTY) begin
            aempty_thr_reg <= pwdata[15:0];
         end
         if (paddr == dpr_pkg::ADDR_IMASK) begin
            imask_reg <= pwdata[dpr_pkg::IRQ_N-1:0];
         end
      end
   end

   // sticky events: a set in the clearing cycle survives
   always_comb begin
      ev = '0;
      ev[dpr_pkg::IRQ_SBE] = b_read && ecc_rd && ecc_i.sbe;
      ev[dpr_pkg::IRQ_DBE] = b_read && ecc_rd && ecc_i.dbe;
      ev[dpr_pkg::IRQ_OVF] = push_req && full_now;
      ev[dpr_pkg::IRQ_UNF] = pop_req && empty_now;
      clr = (wr_acc && paddr == dpr_pkg::ADDR_ISTAT) ? pwdata[dpr_pkg::IRQ_N-1:0] : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_reg <= '0;
         irq       <= 1'b0;
      end else begin
         istat_reg <= (istat_reg & ~clr) | ev;
         irq       <= |(((istat_reg & ~clr) | ev) & imask_reg);
      end
   end
endmodule : dpr_ram_fifo

// ---- testbench/dpr_fabric.sv ----
// fabric-side model that drives both memory ports
`timescale 1ns/1ps
module dpr_fabric (
   // clock
   input  wire logic        pclk,
   // port a
   output logic             a_en,
   output logic             a_we,
   output logic      [14:0] a_addr,
   output logic      [71:0] a_din,
   // port b
   output logic             b_en,
   output logic             b_we,
   output logic      [14:0] b_addr,
   output logic      [71:0] b_din
);
   initial begin
      {a_en, a_we, b_en, b_we} = '0;
      {a_addr, b_addr, a_din, b_din} = '0;
   end

   // one access, taken at the second edge; result checked at the negedge after
   task automatic acc(input logic pb, input logic we, input logic [14:0] ad, input logic [71:0] d);
      @(posedge pclk);
      if (pb) begin
         b_en   <= 1'b1;
         b_we   <= we;
         b_addr <= ad;
         b_din  <= d;
      end else begin
         a_en   <= 1'b1;
         a_we   <= we;
         a_addr <= ad;
         a_din  <= d;
      end
      @(posedge pclk);
      a_en  <= 1'b0;
      b_en  <= 1'b0;
      // released data flips so a stale value never passes for data
      a_din <= ~a_din;
      b_din <= ~b_din;
      @(negedge pclk);
   endtask : acc
endmodule : dpr_fabric

// ---- testbench/dpr_ram_fifo_bench.sv ----
// self-checking bench for the dual-port ram / fifo block
`timescale 1ns/1ps
module dpr_ram_fifo_bench;
   localparam int          DEPTH = 1024;
   localparam int          THR_F = 6;
   localparam int          THR_E = 3;
   localparam logic [71:0] M36   = 72'hf_ffff_ffff;
   logic        pclk, pready, pslverr, err, b_valid, ecc_sbe, ecc_dbe, irq, a_en, a_we, b_en, b_we;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        a_ce = 1'b1, b_ce = 1'b1, casc_in_valid = 1'b0, casc_out_ready = 1'b0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic [14:0] a_addr, b_addr, ad;
   logic [71:0] a_din, b_din, a_dout, b_dout, dd, m;
   logic [71:0] casc_in_data = '0;
   logic [71:0] ext_dec_data = '0;
   logic [63:0] ext_enc_data = '0;
   logic [63:0] ext_dec_out, ed;
   logic [7:0]  ext_enc_check, chk;
   logic        fifo_full, fifo_empty, fifo_afull, fifo_aempty, casc_in_ready, ext_sbe, ext_dbe, e;
   logic [71:0] q[$];
   int          fails = 0, cmp_count = 0, seed = 32'h3003, n, c;

   dpr_ram_fifo DUT (.*);
   dpr_fabric fab (.*);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      check(k < 20, 1);
      if (k >= 20) give_verdict();
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic flags;
      check({fifo_empty, fifo_full}, {q.size() == 0, q.size() >= DEPTH});
      check({fifo_afull, fifo_aempty}, {q.size() >= THR_F, q.size() <= THR_E});
   endtask : flags

   // random address on every push: the fifo makes its own
   task automatic push;
      dd = {8'($random(seed)), $random(seed), $random(seed)};
      fab.acc(0, 1, 15'($random(seed)), dd);
      if (q.size() < DEPTH) q.push_back(dd & M36);
      flags();
   endtask : push

   task automatic pop;
      fab.acc(1, 0, 15'($random(seed)), 0);
      e = q.size() > 0;
      check(b_valid, e);
      if (e) check(b_dout & M36, q.pop_front());
      flags();
   endtask : pop

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, dpr_pkg::ADDR_CTRL, 0);
      check(rd, dpr_pkg::CTRL_RST);
      apb(0, dpr_pkg::ADDR_AFULL, 0);
      check(rd, dpr_pkg::AFULL_RST);
      apb(0, dpr_pkg::ADDR_AEMPTY, 0);
      check(rd, dpr_pkg::AEMPTY_RST);
      apb(0, dpr_pkg::ADDR_FSTAT, 0);
      check(rd, 32'ha);
      apb(0, 8'h1c, 0);
      check({rd, err}, 33'h1);
      // each aspect ratio in true dual-port use
      for (c = 0; c < 6; c++) begin
         apb(1, dpr_pkg::ADDR_CTRL, (c << 8) | (c << 4));
         m  = (c < 3) ? (72'h1 << (1 << c)) - 1 : (72'h1 << (9 << (c - 3))) - 1;
         ad = 15'($unsigned($random(seed)) >> (c + 17));
         dd = {8'($random(seed)), $random(seed), $random(seed)};
         fab.acc(0, 1, ad, dd);
         fab.acc(1, 0, ad, 0);
         check(b_valid, 1);
         check(b_dout & m, dd & m);
         fab.acc(0, 0, ad, 0);
         check(a_dout & m, dd & m);
      end
      // halves hold their own word at one address; width clamps to 18
      apb(1, dpr_pkg::ADDR_CTRL, 32'h662);
      fab.acc(0, 1, 15'h12, dd);
      fab.acc(1, 1, 15'h12, ~dd);
      fab.acc(0, 0, 15'h12, 0);
      fab.acc(1, 0, 15'h12, 0);
      check(a_dout, dd & 72'h3_ffff);
      check(b_dout, ~dd & 72'h3_ffff);
      apb(1, dpr_pkg::ADDR_CTRL, 32'h664);
      fab.acc(0, 1, 15'h5, dd);
      fab.acc(1, 1, 15'h5, ~dd);
      fab.acc(1, 0, 15'h5, 0);
      check(b_dout, dd);
      // no, one and two flipped bits through the codec and the array
      for (n = 0; n < 3; n++) begin
         ed = {$random(seed), $random(seed)};
         @(posedge pclk);
         ext_enc_data <= ed;
         repeat (2) @(negedge pclk);
         chk = ext_enc_check;
         dd  = {chk, ed ^ (64'(n + n / 2) << ($unsigned($random(seed)) % 63))};
         @(posedge pclk);
         ext_dec_data <= dd;
         repeat (2) @(negedge pclk);
         check({ext_sbe, ext_dbe}, {n == 1, n == 2});
         if (n < 2) check(ext_dec_out, ed);
         apb(1, dpr_pkg::ADDR_CTRL, 32'h664);
         fab.acc(0, 1, 15'h9, dd);
         apb(1, dpr_pkg::ADDR_CTRL, 32'h66c);
         fab.acc(1, 0, 15'h9, 0);
         check({ecc_sbe, ecc_dbe}, {n == 1, n == 2});
         if (n < 2) check(b_dout[63:0], ed);
         // encoder output lands in the parity lanes
         if (n == 0) begin
            fab.acc(0, 1, 15'h9, {8'h00, ed});
            apb(1, dpr_pkg::ADDR_CTRL, 32'h664);
            fab.acc(1, 0, 15'h9, 0);
            check(b_dout, dd);
         end
      end
      apb(1, dpr_pkg::ADDR_CTRL, 32'h551);
      apb(1, dpr_pkg::ADDR_AFULL, THR_F);
      apb(1, dpr_pkg::ADDR_AEMPTY, THR_E);
      apb(1, dpr_pkg::ADDR_FRST, 1);
      apb(1, dpr_pkg::ADDR_ISTAT, 32'hf);
      repeat (8) push();
      repeat (9) pop();
      apb(0, dpr_pkg::ADDR_ISTAT, 0);
      check({rd, irq}, 33'h10);
      apb(1, dpr_pkg::ADDR_IMASK, 32'h8);
      repeat (2) @(negedge pclk);
      check(irq, 1);
      apb(1, dpr_pkg::ADDR_ISTAT, 32'h8);
      repeat (2) @(negedge pclk);
      check(irq, 0);
      repeat (DEPTH + 2) push();
      apb(0, dpr_pkg::ADDR_ISTAT, 0);
      check(rd, 32'h4);
      repeat (DEPTH + 1) pop();
      // multirate: each side moves only on its own enable
      apb(1, dpr_pkg::ADDR_CTRL, 32'h1551);
      a_ce <= 1'b0;
      fab.acc(0, 1, 15'h0, dd);
      check(fifo_empty, 1);
      @(posedge pclk);
      a_ce <= 1'b1;
      b_ce <= 1'b0;
      push();
      fab.acc(1, 0, 15'h0, 0);
      check(b_valid, 0);
      @(posedge pclk);
      b_ce <= 1'b1;
      pop();
      // cascade: upstream word in, drained while downstream has room
      apb(1, dpr_pkg::ADDR_CTRL, 32'h2551);
      @(posedge pclk);
      casc_in_valid <= 1'b1;
      casc_in_data  <= dd;
      @(posedge pclk);
      casc_in_valid  <= 1'b0;
      casc_out_ready <= 1'b1;
      @(posedge pclk);
      casc_out_ready <= 1'b0;
      @(negedge pclk);
      check({casc_in_ready, b_valid}, 2'b11);
      check(b_dout & M36, dd & M36);
      give_verdict();
   end
endmodule : dpr_ram_fifo_bench

// ---- testbench/dpr_ram_fifo_props.sv ----
// port-level assertion checker for the ram / fifo block
`timescale 1ns/1ps
module dpr_ram_fifo_props (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // memory ports and codec
   input wire logic a_en,
   input wire logic b_en,
   input wire logic b_valid,
   input wire logic ecc_sbe,
   input wire logic ecc_dbe,
   input wire logic ext_sbe,
   input wire logic ext_dbe,
   // fifo and cascade
   input wire logic fifo_full,
   input wire logic fifo_empty,
   input wire logic fifo_aempty,
   input wire logic casc_in_valid,
   input wire logic casc_out_ready
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_APB_ONE_ACCESS: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb access not exactly one cycle");
   AST_FLAG_EXCL: assert property (!(fifo_full && fifo_empty))
      else $error("full and empty together");
   AST_EMPTY_AEMPTY: assert property (fifo_empty |-> fifo_aempty)
      else $error("empty without almost-empty");
   AST_ECC_EXCL: assert property (!(ecc_sbe && ecc_dbe))
      else $error("single and double error together");
   AST_ECC_ON_VALID: assert property ((ecc_sbe || ecc_dbe) |-> b_valid)
      else $error("ecc flag outside a read result");
   AST_EXT_EXCL: assert property (!(ext_sbe && ext_dbe))
      else $error("codec flags both set");
   AST_VALID_CAUSE: assert property (b_valid |-> $past(b_en) || $past(casc_out_ready))
      else $error("read result without a read");
   AST_FULL_LEAVE: assert property ($fell(fifo_full) |-> $past(b_en) || $past(casc_out_ready) || $past(psel))
      else $error("full cleared without a pop");
   AST_EMPTY_LEAVE: assert property ($fell(fifo_empty) |-> $past(a_en) || $past(casc_in_valid) || $past(psel))
      else $error("empty cleared without a push");

   COV_FULL: cover property ($rose(fifo_full));
   COV_SBE: cover property (ecc_sbe && b_valid);
   COV_ERR: cover property (pready && pslverr);
endmodule : dpr_ram_fifo_props

bind dpr_ram_fifo dpr_ram_fifo_props u_props (.*);
